// *** hdl/fpx_cvt_sat.sv ***
`timescale 1ns/1ps
module fpx_cvt_sat
  import fpx_pkg::*;
(
  // Operand
  input wire logic dbl_i,
  input wire logic [63:0] operand_i,
  input wire logic to64_i,
  // Outcome
  output logic invalid_o,
  output logic [63:0] sat_o
);

  logic sgn;
  logic [10:0] exp11;
  logic [51:0] frac;
  logic [10:0] lim;
  logic tail_nz;

  always_comb begin
    sgn = dbl_i ? operand_i[63] : operand_i[31];
    if (dbl_i) begin
      exp11 = operand_i[62:52];
      frac = operand_i[51:0];
    end else begin
      if (operand_i[30:23] == 8'hff) begin
        exp11 = FPX_EXP_MAX;
      end else if (operand_i[30:23] == 8'h00) begin
        exp11 = 11'h000;
      end else begin
        exp11 = {3'h0, operand_i[30:23]} + FPX_S2D_BIAS;
      end
      frac = {operand_i[22:0], 29'h0};
    end
    lim = to64_i ? FPX_EXP_2P63 : FPX_EXP_2P31;
    // At the boundary exponent only bits worth at least one integer unit matter
    tail_nz = to64_i ? (frac != 52'h0) : (frac[51:21] != 31'h0);
    // NaN and infinity fall under the exponent test
    if (sgn) begin
      invalid_o = (exp11 > lim) || ((exp11 == lim) && tail_nz); // [RL12] [RL14]
    end else begin
      invalid_o = (exp11 >= lim); // [RL12] [RL14]
    end
    if (to64_i) begin
      sat_o = sgn ? FPX_SAT64_NEG : FPX_SAT64_POS; // [RL14]
    end else begin
      sat_o = {32'h0, sgn ? FPX_SAT32_NEG : FPX_SAT32_POS}; // [RL13]
    end
  end

endmodule

// *** hdl/fpx_exc_unit.sv ***
// Summary of operation
// [RL1] A trapping operation never writes its destination register.
// [RL2] A trapping operation leaves all four condition code fields as they were.
// [RL3] A trapping operation leaves the accrued exception field as it was.
// [RL4] A non-arithmetic floating-point trap leaves the current exception field as it was.
// [RL5] An arithmetic exception trap sets exactly one current bit, the cause.
// [RL6] Software-completed operations must look exactly like hardware ones.
// [RL7] Tininess is judged on the exact unrounded value against the smallest normal.
// [RL8] Underflow trap enabled: any tiny result traps with the underflow bit only.
// [RL9] Underflow masked, inexact enabled: tiny inexact traps with inexact, exact tiny nothing.
// [RL10] Both masked: tiny inexact sets underflow and inexact in current and accrued, no trap.
// [RL11] Underflow masked: underflow is signalled only for tiny and inexact results.
// [RL12] Float to 32-bit integer flags invalid for NaN, infinity or out-of-range operands.
// [RL13] Invalid 32-bit conversion traps if enabled, else saturates by operand sign.
// [RL14] Same for 64-bit conversion with 64-bit saturation values.
// [RL15] The nonstandard-mode bit has no effect on any result.
// [RL16] The default quiet NaN has sign zero, exponent and fraction all ones.
// [RL17] A propagated signalling NaN is delivered with its quiet bit forced on.
`timescale 1ns/1ps
module fpx_exc_unit
  import fpx_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Pipeline request
  input wire fpx_req_type req_i,
  // Completion outcome
  output fpx_cmp_type cmp_o,
  output logic [7:0] fcc_o,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o
);

  typedef struct packed {
    logic [4:0] cexc;
    logic [4:0] aexc;
    logic [4:0] tem;
    logic [2:0] ftt;
    logic ns;
    logic [3:0][1:0] fcc;
    fpx_cmp_type cmp;
    logic [31:0] rdata;
  } fpx_state_type;

  fpx_state_type st_r;
  fpx_state_type st_nxt;

  logic tiny;
  logic [4:0] exc;
  logic [4:0] armed;
  logic [63:0] res_val;
  logic cvt_inv;
  logic [63:0] cvt_sat;
  logic [63:0] default_quiet_nan;
  logic [63:0] qnan;
  logic op_sign;

  fpx_cvt_sat u_cvt (
    .dbl_i(req_i.dbl),
    .operand_i(req_i.operand),
    .to64_i(req_i.kind == FPX_K_CVT64),
    .invalid_o(cvt_inv),
    .sat_o(cvt_sat)
  );

  fpx_nan_fix u_nan (
    .dbl_i(req_i.dbl),
    .operand_i(req_i.operand),
    .default_quiet_nan_o(default_quiet_nan),
    .quiet_o(qnan)
  );

  // Highest-priority pending cause only: nv, of, uf, dz, nx
  function automatic logic [4:0] first_cause(input logic [4:0] v);
    logic [4:0] r;
    logic found;
    r = 5'h00;
    found = 1'b0;
    for (int i = 4; i >= 0; i--) begin
      if (v[i] && !found) begin
        r[i] = 1'b1;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  always_comb begin
    op_sign = req_i.dbl ? req_i.operand[63] : req_i.operand[31];
    // Unrounded exponent, so rounding up to min normal still counts as tiny
    tiny = req_i.unr_nz && (req_i.unr_exp < FPX_MIN_NORM_EXP); // [RL7]
    exc = 5'h00;
    res_val = req_i.result;
    unique case (req_i.kind)
      FPX_K_ARITH: begin
        exc[FPX_NV] = req_i.exc_nv;
        exc[FPX_OF] = req_i.exc_of;
        exc[FPX_DZ] = req_i.exc_dz;
        exc[FPX_NX] = req_i.inexact;
        // Trapped underflow needs only tininess; untrapped needs loss too
        exc[FPX_UF] = st_r.tem[FPX_UF] ? tiny : (tiny && req_i.inexact); // [RL8] [RL11]
        if (req_i.nan_gen) begin
          res_val = default_quiet_nan; // [RL16]
        end else if (req_i.snan_prop) begin
          res_val = qnan; // [RL17]
        end
      end
      FPX_K_CVT32, FPX_K_CVT64: begin
        exc[FPX_NV] = cvt_inv; // [RL12] [RL14]
        exc[FPX_NX] = req_i.inexact && !cvt_inv;
        if (cvt_inv) begin
          res_val = cvt_sat; // [RL13] [RL14]
        end
      end
      FPX_K_INCOMPLETE, FPX_K_MISSING: begin
        exc = 5'h00;
      end
      default: begin
        exc = 5'h00;
      end
    endcase
    armed = exc & st_r.tem;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.cmp.res_we = 1'b0;
    st_nxt.cmp.trap_ieee = 1'b0;
    st_nxt.cmp.trap_other = 1'b0;
    st_nxt.rdata = 32'h0;
    // Software write first, so hardware updates below win a same-cycle clash
    if (wr_i && addr_i == FPX_FSR_ADDR) begin
      st_nxt.cexc = wdata_i[FPX_CEXC_LSB +: 5];
      st_nxt.aexc = wdata_i[FPX_AEXC_LSB +: 5];
      st_nxt.fcc[0] = wdata_i[FPX_FP_CONDITION_CODE_FIELD_LSB +: 2];
      st_nxt.ftt = wdata_i[FPX_FTT_LSB +: 3];
      st_nxt.ns = wdata_i[FPX_NS_BIT]; // Stored only, never steers results [RL15]
      st_nxt.tem = wdata_i[FPX_TEM_LSB +: 5];
    end else if (wr_i && addr_i == FPX_FCCX_ADDR) begin
      st_nxt.fcc[1] = wdata_i[1:0];
      st_nxt.fcc[2] = wdata_i[3:2];
      st_nxt.fcc[3] = wdata_i[5:4];
    end
    if (rd_i) begin
      if (addr_i == FPX_FSR_ADDR) begin
        st_nxt.rdata[FPX_CEXC_LSB +: 5] = st_r.cexc;
        st_nxt.rdata[FPX_AEXC_LSB +: 5] = st_r.aexc;
        st_nxt.rdata[FPX_FP_CONDITION_CODE_FIELD_LSB +: 2] = st_r.fcc[0];
        st_nxt.rdata[FPX_FTT_LSB +: 3] = st_r.ftt;
        st_nxt.rdata[FPX_NS_BIT] = st_r.ns;
        st_nxt.rdata[FPX_TEM_LSB +: 5] = st_r.tem;
      end else if (addr_i == FPX_FCCX_ADDR) begin
        st_nxt.rdata[5:0] = {st_r.fcc[3], st_r.fcc[2], st_r.fcc[1]};
      end
    end
    if (req_i.valid) begin
      if (req_i.kind == FPX_K_INCOMPLETE || req_i.kind == FPX_K_MISSING) begin
        // Software finishes the op later; only ftt and the trap flag change now [RL6]
        st_nxt.cmp.trap_other = 1'b1;
        st_nxt.cexc = st_r.cexc; // [RL4]
        st_nxt.aexc = st_r.aexc; // [RL3]
        st_nxt.fcc = st_r.fcc; // [RL2]
        st_nxt.ftt = (req_i.kind == FPX_K_INCOMPLETE) ? FPX_FTT_INCOMPLETE : FPX_FTT_MISSING;
      end else if (armed != 5'h00) begin
        st_nxt.cmp.trap_ieee = 1'b1; // [RL9] [RL13] [RL14]
        st_nxt.cexc = first_cause(armed); // [RL5] [RL8] [RL9]
        st_nxt.aexc = st_r.aexc; // [RL3]
        st_nxt.fcc = st_r.fcc; // [RL2]
        st_nxt.ftt = FPX_FTT_IEEE;
      end else begin
        st_nxt.cmp.res_we = (req_i.kind != FPX_K_ARITH) || !req_i.fcc_wr; // [RL1]
        st_nxt.cmp.res_data = res_val;
        st_nxt.cexc = exc; // [RL10]
        st_nxt.aexc = st_nxt.aexc | exc; // [RL10]
        st_nxt.ftt = FPX_FTT_NONE;
        if (req_i.kind == FPX_K_ARITH && req_i.fcc_wr) begin
          st_nxt.fcc[req_i.fcc_idx] = req_i.fcc_val;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_r.cexc <= FPX_EXC_RST;
      st_r.aexc <= FPX_EXC_RST;
      st_r.tem <= FPX_TEM_RST;
      st_r.ftt <= FPX_FTT_NONE;
      st_r.ns <= 1'b0;
      st_r.fcc <= {4{FPX_FCC_RST}};
      st_r.cmp <= '0;
      st_r.rdata <= 32'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cmp_o = st_r.cmp;
  assign fcc_o = st_r.fcc;
  assign rdata_o = st_r.rdata;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  logic arith_v;
  assign arith_v = req_i.valid && req_i.kind == FPX_K_ARITH;

  property p_no_write_on_trap;
    (st_r.cmp.trap_ieee || st_r.cmp.trap_other) |-> !st_r.cmp.res_we;
  endproperty
  a_no_write_on_trap: assert property (p_no_write_on_trap) // [RL1]
    else $error("trap wrote a destination register");

  property p_fcc_hold;
    (st_r.cmp.trap_ieee || st_r.cmp.trap_other) && !$past(wr_i) |-> $stable(st_r.fcc);
  endproperty
  a_fcc_hold: assert property (p_fcc_hold) // [RL2]
    else $error("condition codes changed on trap");

  property p_aexc_hold;
    (st_r.cmp.trap_ieee || st_r.cmp.trap_other) && !$past(wr_i) |-> $stable(st_r.aexc);
  endproperty
  a_aexc_hold: assert property (p_aexc_hold) // [RL3]
    else $error("accrued field changed on trap");

  property p_cexc_other;
    st_r.cmp.trap_other && !$past(wr_i) |-> $stable(st_r.cexc);
  endproperty
  a_cexc_other: assert property (p_cexc_other) // [RL4]
    else $error("current field changed on non-arithmetic trap");

  property p_onehot;
    st_r.cmp.trap_ieee |-> $onehot(st_r.cexc) && st_r.ftt == FPX_FTT_IEEE;
  endproperty
  a_onehot: assert property (p_onehot) // [RL5]
    else $error("arithmetic trap without a single cause bit");

  property p_uf_trap;
    arith_v && tiny && st_r.tem[FPX_UF] && !(req_i.exc_nv && st_r.tem[FPX_NV])
      && !(req_i.exc_of && st_r.tem[FPX_OF])
      |=> st_r.cmp.trap_ieee && st_r.cexc == 5'h04;
  endproperty
  a_uf_trap: assert property (p_uf_trap) // [RL8]
    else $error("tiny result with underflow trap enabled did not trap");

  property p_nx_trap;
    arith_v && tiny && req_i.inexact && st_r.tem == 5'h01
      |=> st_r.cmp.trap_ieee && st_r.cexc == 5'h01;
  endproperty
  a_nx_trap: assert property (p_nx_trap) // [RL9]
    else $error("tiny inexact did not trap with inexact");

  property p_masked_tiny;
    arith_v && tiny && req_i.inexact && st_r.tem == 5'h00
      |=> !st_r.cmp.trap_ieee && st_r.cexc[FPX_UF] && st_r.cexc[FPX_NX]
      && st_r.aexc[FPX_UF] && st_r.aexc[FPX_NX];
  endproperty
  a_masked_tiny: assert property (p_masked_tiny) // [RL10]
    else $error("masked tiny inexact did not set both fields");

  property p_exact_tiny;
    arith_v && tiny && !req_i.inexact && !st_r.tem[FPX_UF] |=> !st_r.cexc[FPX_UF];
  endproperty
  a_exact_tiny: assert property (p_exact_tiny) // [RL11]
    else $error("exact tiny result flagged underflow");

  property p_cvt32_sat;
    req_i.valid && req_i.kind == FPX_K_CVT32 && cvt_inv && !st_r.tem[FPX_NV]
      |=> st_r.cmp.res_we
      && st_r.cmp.res_data[31:0] == ($past(op_sign) ? FPX_SAT32_NEG : FPX_SAT32_POS);
  endproperty
  a_cvt32_sat: assert property (p_cvt32_sat) // [RL13]
    else $error("invalid 32-bit conversion did not saturate");

  property p_cvt64_sat;
    req_i.valid && req_i.kind == FPX_K_CVT64 && cvt_inv && !st_r.tem[FPX_NV]
      |=> st_r.cmp.res_we
      && st_r.cmp.res_data == ($past(op_sign) ? FPX_SAT64_NEG : FPX_SAT64_POS);
  endproperty
  a_cvt64_sat: assert property (p_cvt64_sat) // [RL14]
    else $error("invalid 64-bit conversion did not saturate");

  property p_default_quiet_nan;
    arith_v && req_i.nan_gen && !req_i.dbl && armed == 5'h00
      |=> st_r.cmp.res_data == {32'h0, FPX_DQNAN32};
  endproperty
  a_default_quiet_nan: assert property (p_default_quiet_nan) // [RL16]
    else $error("default NaN encoding wrong");

  property p_snan_quiet;
    arith_v && req_i.snan_prop && !req_i.nan_gen && req_i.dbl && armed == 5'h00
      |=> st_r.cmp.res_data == ($past(req_i.operand) | (64'h1 << FPX_QBIT64));
  endproperty
  a_snan_quiet: assert property (p_snan_quiet) // [RL17]
    else $error("propagated signalling NaN not quieted");

  c_uf_trap: cover property (arith_v && tiny && st_r.tem[FPX_UF] ##1 st_r.cmp.trap_ieee);
  c_cvt_trap: cover property (req_i.valid && cvt_inv && st_r.tem[FPX_NV]
    ##1 st_r.cmp.trap_ieee);
  c_other: cover property (st_r.cmp.trap_other);
  c_masked: cover property (arith_v && tiny && req_i.inexact && st_r.tem == 5'h00);
  c_clash: cover property (wr_i && arith_v && !st_r.cmp.trap_ieee);

endmodule

// *** hdl/fpx_nan_fix.sv ***
`timescale 1ns/1ps
module fpx_nan_fix
  import fpx_pkg::*;
(
  // Operand
  input wire logic dbl_i,
  input wire logic [63:0] operand_i,
  // NaN results
  output logic [63:0] default_quiet_nan_o,
  output logic [63:0] quiet_o
);

  always_comb begin
    default_quiet_nan_o = dbl_i ? FPX_DQNAN64 : {32'h0, FPX_DQNAN32}; // [RL16]
    quiet_o = dbl_i ? operand_i : {32'h0, operand_i[31:0]};
    if (dbl_i) begin
      quiet_o[FPX_QBIT64] = 1'b1; // [RL17]
    end else begin
      quiet_o[FPX_QBIT32] = 1'b1; // [RL17]
    end
  end

endmodule

// *** hdl/fpx_pkg.sv ***
package fpx_pkg;

  // Status word field positions (word at FPX_FSR_ADDR)
  localparam int FPX_CEXC_LSB = 0;
  localparam int FPX_AEXC_LSB = 5;
  localparam int FPX_FP_CONDITION_CODE_FIELD_LSB = 10;
  localparam int FPX_FTT_LSB = 14;
  localparam int FPX_NS_BIT = 22;
  localparam int FPX_TEM_LSB = 23;

  // Register addresses
  localparam logic [7:0] FPX_FSR_ADDR = 8'h00;
  localparam logic [7:0] FPX_FCCX_ADDR = 8'h04;

  // Exception vector bit positions {nv, of, uf, dz, nx}
  localparam int FPX_NV = 4;
  localparam int FPX_OF = 3;
  localparam int FPX_UF = 2;
  localparam int FPX_DZ = 1;
  localparam int FPX_NX = 0;

  // Trap type codes held in the ftt field
  localparam logic [2:0] FPX_FTT_NONE = 3'h0;
  localparam logic [2:0] FPX_FTT_IEEE = 3'h1;
  localparam logic [2:0] FPX_FTT_INCOMPLETE = 3'h2;
  localparam logic [2:0] FPX_FTT_MISSING = 3'h3;

  // Reset values
  localparam logic [4:0] FPX_TEM_RST = 5'h00;
  localparam logic [4:0] FPX_EXC_RST = 5'h00;
  localparam logic [1:0] FPX_FCC_RST = 2'h0;

  // Format constants
  localparam logic signed [12:0] FPX_MIN_NORM_EXP = 13'sh0001;
  localparam logic [10:0] FPX_EXP_MAX = 11'h7ff;
  localparam logic [10:0] FPX_S2D_BIAS = 11'h380;
  localparam logic [10:0] FPX_EXP_2P31 = 11'h41e;
  localparam logic [10:0] FPX_EXP_2P63 = 11'h43e;
  localparam logic [31:0] FPX_DQNAN32 = 32'h7fffffff;
  localparam logic [63:0] FPX_DQNAN64 = 64'h7fffffffffffffff;
  localparam int FPX_QBIT32 = 22;
  localparam int FPX_QBIT64 = 51;
  localparam logic [63:0] FPX_SAT64_POS = 64'h7fffffffffffffff;
  localparam logic [63:0] FPX_SAT64_NEG = 64'h8000000000000000;
  localparam logic [31:0] FPX_SAT32_POS = 32'h7fffffff;
  localparam logic [31:0] FPX_SAT32_NEG = 32'h80000000;

  typedef enum logic [2:0] {
    FPX_K_ARITH,
    FPX_K_CVT32,
    FPX_K_CVT64,
    FPX_K_INCOMPLETE,
    FPX_K_MISSING
  } fpx_kind_type;

  // One completed operation from the pipeline
  typedef struct packed {
    logic valid;
    fpx_kind_type kind;
    logic dbl;
    logic [63:0] operand;
    logic [63:0] result;
    logic exc_nv;
    logic exc_of;
    logic exc_dz;
    logic inexact;
    logic signed [12:0] unr_exp;
    logic unr_nz;
    logic nan_gen;
    logic snan_prop;
    logic fcc_wr;
    logic [1:0] fcc_idx;
    logic [1:0] fcc_val;
  } fpx_req_type;

  // Registered outcome towards the register file and trap logic
  typedef struct packed {
    logic res_we;
    logic [63:0] res_data;
    logic trap_ieee;
    logic trap_other;
  } fpx_cmp_type;

endpackage

// *** verification/fpx_pipe_model.sv ***
`timescale 1ns/1ps
module fpx_pipe_model
  import fpx_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Operation from the sequencer
  input wire fpx_req_type nxt_i,
  // Towards the exception unit
  output fpx_req_type req_o
);
  // Launch on a clean edge, one stage as the issue pipe has
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      req_o <= '0;
    end else begin
      req_o <= nxt_i;
    end
  end
endmodule

// *** verification/tb_fp_ieee_exception_policy.sv ***
`timescale 1ns/1ps
module tb_fp_ieee_exception_policy;
  import fpx_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  fpx_req_type nxt = '0;
  fpx_req_type req;
  fpx_cmp_type cmp;
  logic [7:0] fcc_o;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [4:0] m_tem, m_cexc, m_aexc;
  logic m_ns;
  logic [2:0] m_ftt;
  logic [31:0] sg_ops [4] = '{32'h4f000000, 32'hcf000000, 32'hcf000001, 32'h7fc00000};
  logic [1:0] m_fcc [4];
  logic [63:0] cv_ops [10] = '{64'h41e0000000000000, 64'h41dfffffffc00000,
    64'hc1e0000000000000, 64'hc1e0000000100000, 64'hc1e0000000200000,
    64'h43e0000000000000, 64'hc3e0000000000000, 64'hc3e0000000000001,
    64'h7ff8000000000000, 64'hfff0000000000000};

  always #50 clk_sys_i = ~clk_sys_i;

  fpx_pipe_model fpx_pipe_model_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .nxt_i(nxt),
    .req_o(req));
  fpx_exc_unit fpx_exc_unit_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req),
    .cmp_o(cmp), .fcc_o(fcc_o), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata));

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard, far above the expected run length
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      close_out();
    end
  end

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  function automatic logic [31:0] status_word();
    logic [31:0] w;
    w = '0;
    w[FPX_CEXC_LSB +: 5] = m_cexc;
    w[FPX_AEXC_LSB +: 5] = m_aexc;
    w[FPX_FP_CONDITION_CODE_FIELD_LSB +: 2] = m_fcc[0];
    w[FPX_FTT_LSB +: 3] = m_ftt;
    w[FPX_NS_BIT] = m_ns;
    w[FPX_TEM_LSB +: 5] = m_tem;
    return w;
  endfunction

  task automatic check_regs();
    logic [31:0] d;
    bus_rd(FPX_FSR_ADDR, d);
    chk("status", {32'h0, d}, {32'h0, status_word()});
    bus_rd(FPX_FCCX_ADDR, d);
    chk("fcc_ext", {32'h0, d}, {58'h0, m_fcc[3], m_fcc[2], m_fcc[1]});
    chk("fcc_o", {56'h0, fcc_o}, {56'h0, m_fcc[3], m_fcc[2], m_fcc[1], m_fcc[0]});
  endtask

  task automatic load_regs(input logic [31:0] w, input logic [5:0] x);
    w = w & 32'h0fc00fff;
    bus_wr(FPX_FSR_ADDR, w);
    bus_wr(FPX_FCCX_ADDR, {26'h0, x});
    m_cexc = w[FPX_CEXC_LSB +: 5];
    m_aexc = w[FPX_AEXC_LSB +: 5];
    m_fcc[0] = w[FPX_FP_CONDITION_CODE_FIELD_LSB +: 2];
    m_ns = w[FPX_NS_BIT];
    m_tem = w[FPX_TEM_LSB +: 5];
    m_ftt = FPX_FTT_NONE;
    {m_fcc[3], m_fcc[2], m_fcc[1]} = x;
  endtask

  task automatic run_op(input fpx_req_type r, input logic [63:0] data, input logic [4:0] flags);
    logic [4:0] en, hot;
    logic other, trap, we;
    en = flags & m_tem;
    hot = en[4] ? 5'h10 : en[3] ? 5'h08 : en[2] ? 5'h04 : en[1] ? 5'h02 : en[0] ? 5'h01 : 5'h00;
    other = (r.kind == FPX_K_INCOMPLETE) || (r.kind == FPX_K_MISSING);
    trap = !other && (en != 5'h00);
    we = !other && !trap && !r.fcc_wr;
    @(posedge clk_sys_i);
    nxt <= r;
    @(posedge clk_sys_i);
    nxt <= '0;
    @(posedge clk_sys_i);
    #1;
    chk("trap_ieee", cmp.trap_ieee, trap);
    chk("trap_other", cmp.trap_other, other);
    chk("res_we", cmp.res_we, we);
    if (we) chk("res_data", cmp.res_data, data);
    if (other) begin
      m_ftt = (r.kind == FPX_K_INCOMPLETE) ? FPX_FTT_INCOMPLETE : FPX_FTT_MISSING;
    end else if (trap) begin
      m_cexc = hot;
      m_ftt = FPX_FTT_IEEE;
    end else begin
      m_cexc = flags;
      m_aexc = m_aexc | flags;
      m_ftt = FPX_FTT_NONE;
      if (r.fcc_wr) m_fcc[r.fcc_idx] = r.fcc_val;
    end
    check_regs();
  endtask

  function automatic logic [4:0] arith_flags(fpx_req_type r);
    logic tiny;
    logic uf;
    tiny = r.unr_nz && (r.unr_exp < FPX_MIN_NORM_EXP);
    uf = m_tem[FPX_UF] ? tiny : (tiny && r.inexact);
    return {r.exc_nv, r.exc_of, uf, r.exc_dz, r.inexact};
  endfunction

  function automatic logic [63:0] arith_data(fpx_req_type r);
    if (r.nan_gen) return r.dbl ? FPX_DQNAN64 : {32'h0, FPX_DQNAN32};
    if (r.snan_prop) begin
      if (r.dbl) return r.operand | (64'h1 << FPX_QBIT64);
      return {32'h0, r.operand[31:0] | (32'h1 << FPX_QBIT32)};
    end
    return r.result;
  endfunction

  // Negative side reaches one unit further than the positive side
  function automatic logic cvt_bad(input logic [63:0] op, input logic to64);
    logic [10:0] e, lim;
    e = op[62:52];
    lim = to64 ? FPX_EXP_2P63 : FPX_EXP_2P31;
    if (e == FPX_EXP_MAX) return 1'b1;
    if (!op[63]) return e >= lim;
    if (e != lim) return e > lim;
    return to64 ? (op[51:0] != 52'h0) : (op[51:0] >= 52'h200000);
  endfunction

  initial begin
    fpx_req_type r;
    logic [31:0] d;
    logic bad;
    logic [63:0] want;
    void'($urandom(89596));
    m_tem = '0;
    m_cexc = '0;
    m_aexc = '0;
    m_ns = 1'b0;
    m_ftt = '0;
    foreach (m_fcc[i]) m_fcc[i] = 2'h0;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    check_regs();
    bus_wr(8'h08, 32'hffffffff);
    bus_rd(8'h08, d);
    chk("unmapped", {32'h0, d}, 64'h0);
    @(posedge clk_sys_i);
    #1;
    chk("rdata_idle", {32'h0, rdata}, 64'h0);
    check_regs();
    $display("Test reset_map done");
    for (int i = 0; i < 80; i++) begin
      load_regs($urandom, 6'($urandom));
      r = '0;
      r.valid = 1'b1;
      r.kind = FPX_K_ARITH;
      r.dbl = 1'($urandom);
      r.operand = {$urandom, $urandom};
      r.result = {r.dbl ? $urandom : 32'h0, $urandom};
      r.exc_nv = ($urandom_range(0, 3) == 0);
      r.exc_of = ($urandom_range(0, 3) == 0);
      r.exc_dz = ($urandom_range(0, 3) == 0);
      r.inexact = 1'($urandom);
      r.unr_exp = 13'(int'($urandom_range(0, 4)) - 2);
      r.unr_nz = 1'($urandom);
      d = $urandom_range(0, 3);
      r.nan_gen = (d == 0);
      r.snan_prop = (d == 1);
      r.fcc_wr = ($urandom_range(0, 3) == 0);
      r.fcc_idx = 2'($urandom);
      r.fcc_val = 2'($urandom);
      run_op(r, arith_data(r), arith_flags(r));
    end
    $display("Test arith_random done");
    for (int p = 0; p < 2; p++) begin
      foreach (cv_ops[i]) begin
        for (int w = 0; w < 2; w++) begin
          load_regs({4'h0, p[0], 4'h0, 23'($urandom)}, 6'($urandom));
          r = '0;
          r.valid = 1'b1;
          r.kind = w ? FPX_K_CVT64 : FPX_K_CVT32;
          r.dbl = 1'b1;
          r.operand = cv_ops[i];
          r.result = {w ? $urandom : 32'h0, $urandom};
          bad = cvt_bad(cv_ops[i], w[0]);
          // Datapath result stays random so a missing saturation shows
          want = r.result;
          if (bad && w) want = cv_ops[i][63] ? FPX_SAT64_NEG : FPX_SAT64_POS;
          if (bad && !w) want = {32'h0, (cv_ops[i][63] ? FPX_SAT32_NEG : FPX_SAT32_POS)};
          run_op(r, want, {bad, 4'h0});
        end
      end
    end
    $display("Test convert_bounds done");
    foreach (sg_ops[i]) begin
      load_regs(32'h0, 6'h0);
      r = '0;
      r.valid = 1'b1;
      r.kind = FPX_K_CVT32;
      r.operand = {32'h0, sg_ops[i]};
      r.result = {32'h0, $urandom};
      // Only the exact negative boundary converts cleanly
      bad = (i != 1);
      want = bad ? {32'h0, (sg_ops[i][31] ? FPX_SAT32_NEG : FPX_SAT32_POS)} : r.result;
      run_op(r, want, {bad, 4'h0});
    end
    $display("Test convert_single done");
    // Underflow table: trap masks x inexact x tiny or minimum normal
    for (int t = 0; t < 12; t++) begin
      load_regs({4'h0, ((t % 3 == 0) ? 5'h04 : ((t % 3 == 1) ? 5'h01 : 5'h00)), 23'h0}, 6'h0);
      r = '0;
      r.valid = 1'b1;
      r.kind = FPX_K_ARITH;
      r.result = {32'h0, $urandom};
      r.inexact = ((t / 3) % 2 == 1);
      r.unr_exp = (t < 6) ? 13'sh0000 : FPX_MIN_NORM_EXP;
      r.unr_nz = 1'b1;
      run_op(r, arith_data(r), arith_flags(r));
    end
    $display("Test underflow_table done");
    for (int k = 0; k < 6; k++) begin
      load_regs($urandom, 6'($urandom));
      r = '0;
      r.valid = 1'b1;
      r.kind = k[0] ? FPX_K_MISSING : FPX_K_INCOMPLETE;
      r.exc_nv = 1'b1;
      r.inexact = 1'b1;
      r.fcc_wr = 1'b1;
      run_op(r, 64'h0, 5'h00);
    end
    $display("Test other_trap done");
    close_out();
  end
endmodule
